// *** inc/aim_pkg.sv ***
`default_nettype none
package aim_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned DIO_N = 16;
  localparam int unsigned SRC_N = 25;

  localparam logic [31:0] IRQ_ENABLE_OFFSET = 32'h0000_7004;
  localparam logic [31:0] ADC_CONTROL_OFFSET = 32'h0000_7008;

  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_ENABLE_MASK = 32'h0100_ffff;
  localparam logic [31:0] ADC_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADC_CONTROL_MASK = 32'h0000_0033;

  localparam int unsigned CTR_BIT = 24;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned TRIG_LSB = 4;
  localparam int unsigned GLOBAL_RST_BIT = 14;
  localparam int unsigned ADC_RST_BIT = 15;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] TRIG_OFF = 2'h0;
  localparam logic [1:0] TRIG_IN = 2'h1;
  localparam logic [1:0] TRIG_OUT = 2'h2;

  typedef enum logic [2:0] {
    CONV_IDLE,
    CONV_ARMED_ONE,
    CONV_SPENT,
    CONV_ARMED_RUN,
    CONV_RUNNING
  } aim_conv_state_type;
endpackage
`default_nettype wire

// *** hw/aim_regs.sv ***
// Contract
// - Enable bit zero blocks that function's interrupt.
// - Bits 0-15 digital channels, bit 24 counter.
// - Reset clears every interrupt enable bit.
// - Byte-lane writes and reads for 8/16/32 bits.
// - Unused bits stay low, read zero.
// - Mode 00 stops conversions; 11 reserved.
// - Single mode: one conversion, then starts ignored until mode leaves single.
// - Channel timer sequences each started conversion.
// - Continuous mode repeats after first start.
// - Follow-on conversions come from interval timer.
// - Trigger field selects off, input, output.
// - Output mode drives timer triggers on pin.
// - Trigger output can pace other modules.
// - Trigger input is line three, active high.
// - Trigger output is line nine, active high.
// - Masked function never sets pending flag.
// - Control bit 14 resets the enable register.
`timescale 1ns/100ps
`default_nettype none
module aim_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [aim_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [aim_pkg::BE_W-1:0] reg_be,
  input wire logic [aim_pkg::DATA_W-1:0] reg_wdata,
  output logic [aim_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [aim_pkg::DIO_N-1:0] dio_irq_event,
  input wire logic ctr_irq_event,
  output logic [aim_pkg::SRC_N-1:0] irq_pending_set,
  input wire logic sw_start,
  input wire logic timer_tick,
  output logic conv_start,
  input wire logic field_line3_in,
  output logic field_line9_out,
  output logic field_line9_oe
);

  logic [31:0] irq_enable;
  logic [31:0] next_irq_enable;
  logic [31:0] adc_control;
  logic [31:0] next_adc_control;
  logic [31:0] next_reg_rdata;
  logic [aim_pkg::SRC_N-1:0] next_irq_pending_set;
  logic trig_in_prev;
  logic next_conv_start;
  logic next_field_line9_out;
  logic next_field_line9_oe;
  logic next_trig_in_prev;
  aim_pkg::aim_conv_state_type conv_state;
  aim_pkg::aim_conv_state_type next_conv_state;
  logic hit_enable;
  logic hit_control;
  logic global_rst;
  logic [1:0] eff_mode;
  logic [1:0] eff_trig;
  logic ext_event;
  logic start_event;

  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [31:0] keep
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res & keep;
  endfunction

  // Reserved code 11 acts as disabled, while the register keeps what was written.
  function automatic logic [1:0] legal_code(input logic [1:0] code);
    return (code == 2'h3) ? 2'h0 : code;
  endfunction

  assign hit_enable = (reg_addr == aim_pkg::IRQ_ENABLE_OFFSET);
  assign hit_control = (reg_addr == aim_pkg::ADC_CONTROL_OFFSET);
  assign global_rst = reg_wr && hit_control && reg_be[1]
      && reg_wdata[aim_pkg::GLOBAL_RST_BIT];
  assign eff_mode = legal_code(adc_control[aim_pkg::MODE_LSB +: 2]);
  assign eff_trig = legal_code(adc_control[aim_pkg::TRIG_LSB +: 2]);
  // Rising edge of the active-high trigger input, only while input mode is set.
  assign ext_event = (eff_trig == aim_pkg::TRIG_IN) && field_line3_in && !trig_in_prev;
  assign start_event = sw_start || ext_event;

  always_comb begin
    next_irq_enable = irq_enable;
    next_adc_control = adc_control;
    if (reg_wr && hit_enable) begin
      next_irq_enable = merge_lanes(irq_enable, reg_wdata, reg_be,
          aim_pkg::IRQ_ENABLE_MASK);
    end
    if (reg_wr && hit_control) begin
      next_adc_control = merge_lanes(adc_control, reg_wdata, reg_be,
          aim_pkg::ADC_CONTROL_MASK);
      if (reg_be[1] && reg_wdata[aim_pkg::ADC_RST_BIT]) begin
        next_adc_control = aim_pkg::ADC_CONTROL_RESET;
      end
    end
    // The soft reset clears the enables, yet the control write of that access still lands.
    if (global_rst) begin
      next_irq_enable = aim_pkg::IRQ_ENABLE_RESET;
    end
  end

  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd && hit_enable) begin
      next_reg_rdata = irq_enable;
    end else if (reg_rd && hit_control) begin
      next_reg_rdata = adc_control;
    end
    // Each source only reaches the pending flags when its enable bit is set.
    next_irq_pending_set = {ctr_irq_event && irq_enable[aim_pkg::CTR_BIT],
        {(aim_pkg::CTR_BIT - aim_pkg::DIO_N){1'b0}},
        dio_irq_event & irq_enable[aim_pkg::DIO_N-1:0]};
  end

  always_comb begin
    next_conv_state = conv_state;
    next_conv_start = 1'b0;
    unique case (conv_state)
      aim_pkg::CONV_IDLE: begin
        if (eff_mode == aim_pkg::MODE_SINGLE) begin
          next_conv_state = aim_pkg::CONV_ARMED_ONE;
        end else if (eff_mode == aim_pkg::MODE_CONT) begin
          next_conv_state = aim_pkg::CONV_ARMED_RUN;
        end
      end
      aim_pkg::CONV_ARMED_ONE: begin
        if (eff_mode != aim_pkg::MODE_SINGLE) begin
          next_conv_state = aim_pkg::CONV_IDLE;
        end else if (start_event) begin
          next_conv_start = 1'b1;
          next_conv_state = aim_pkg::CONV_SPENT;
        end
      end
      aim_pkg::CONV_SPENT: begin
        // Further starts are ignored until the mode changes to anything other than single.
        if (eff_mode != aim_pkg::MODE_SINGLE) begin
          next_conv_state = aim_pkg::CONV_IDLE;
        end
      end
      aim_pkg::CONV_ARMED_RUN: begin
        if (eff_mode != aim_pkg::MODE_CONT) begin
          next_conv_state = aim_pkg::CONV_IDLE;
        end else if (start_event) begin
          next_conv_start = 1'b1;
          next_conv_state = aim_pkg::CONV_RUNNING;
        end
      end
      aim_pkg::CONV_RUNNING: begin
        if (eff_mode != aim_pkg::MODE_CONT) begin
          next_conv_state = aim_pkg::CONV_IDLE;
        end else if (timer_tick) begin
          next_conv_start = 1'b1;
        end
      end
      default: begin
        next_conv_state = aim_pkg::CONV_IDLE;
      end
    endcase
    next_trig_in_prev = field_line3_in;
  end

  always_comb begin
    next_field_line9_oe = (eff_trig == aim_pkg::TRIG_OUT);
    next_field_line9_out = next_field_line9_oe && timer_tick;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_enable <= aim_pkg::IRQ_ENABLE_RESET;
      adc_control <= aim_pkg::ADC_CONTROL_RESET;
    end else begin
      irq_enable <= next_irq_enable;
      adc_control <= next_adc_control;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
      irq_pending_set <= '0;
    end else begin
      reg_rdata <= next_reg_rdata;
      irq_pending_set <= next_irq_pending_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conv_state <= aim_pkg::CONV_IDLE;
      conv_start <= 1'b0;
      trig_in_prev <= 1'b0;
    end else begin
      conv_state <= next_conv_state;
      conv_start <= next_conv_start;
      trig_in_prev <= next_trig_in_prev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      field_line9_out <= 1'b0;
      field_line9_oe <= 1'b0;
    end else begin
      field_line9_out <= next_field_line9_out;
      field_line9_oe <= next_field_line9_oe;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_mask_blocks_dio: assert property (
    !irq_enable[0] |=> !irq_pending_set[0])
    else $error("masked channel 0 raised pending");
  chk_ctr_bit_gate: assert property (
    ctr_irq_event && irq_enable[aim_pkg::CTR_BIT] |=> irq_pending_set[aim_pkg::CTR_BIT])
    else $error("enabled counter event not passed");
  chk_unused_pending_low: assert property (
    irq_pending_set[aim_pkg::CTR_BIT-1:aim_pkg::DIO_N] == '0)
    else $error("unused pending bit set");
  chk_enable_reset_zero: assert property (
    $past(sys_rst) |-> irq_enable == aim_pkg::IRQ_ENABLE_RESET)
    else $error("enable not cleared by reset");
  chk_reserved_bits_zero: assert property (
    (irq_enable & ~aim_pkg::IRQ_ENABLE_MASK) == '0)
    else $error("reserved enable bit set");
  chk_byte_lane_write: assert property (
    reg_wr && hit_enable && !global_rst && reg_be == 4'h1
      |=> irq_enable[15:8] == $past(irq_enable[15:8])
        && irq_enable[7:0] == $past(reg_wdata[7:0]))
    else $error("byte lane write wrong");
  chk_swrst_clears: assert property (
    global_rst |=> irq_enable == '0)
    else $error("software reset left enables set");
  chk_off_no_start: assert property (
    eff_mode == aim_pkg::MODE_OFF |=> !conv_start)
    else $error("start while conversions disabled");
  chk_single_once: assert property (
    conv_start && conv_state == aim_pkg::CONV_SPENT
      |-> ##1 (!conv_start)[*2])
    else $error("second single conversion");
  chk_cont_tick_start: assert property (
    conv_state == aim_pkg::CONV_RUNNING && eff_mode == aim_pkg::MODE_CONT && timer_tick
      |=> conv_start)
    else $error("tick did not start conversion");
  chk_trig_in_start: assert property (
    conv_state == aim_pkg::CONV_ARMED_ONE && eff_mode == aim_pkg::MODE_SINGLE
      && eff_trig == aim_pkg::TRIG_IN && field_line3_in && !trig_in_prev
      |=> conv_start && conv_state == aim_pkg::CONV_SPENT)
    else $error("trigger input did not start");
  chk_trig_out_follow: assert property (
    eff_trig == aim_pkg::TRIG_OUT && timer_tick |=> field_line9_out && field_line9_oe)
    else $error("timer trigger not driven out");
  chk_reserved_no_drive: assert property (
    adc_control[aim_pkg::TRIG_LSB +: 2] != aim_pkg::TRIG_OUT |=> !field_line9_out)
    else $error("trigger driven outside output mode");
  chk_pending_follows: assert property (
    !$past(sys_rst) |-> irq_pending_set[aim_pkg::DIO_N-1:0]
      == $past(dio_irq_event & irq_enable[aim_pkg::DIO_N-1:0]))
    else $error("pending flags do not follow enabled events");
  chk_ctrl_unused_zero: assert property (
    (adc_control & ~aim_pkg::ADC_CONTROL_MASK) == '0)
    else $error("unused control bit set");
  chk_idle_rdata_zero: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero without a read");
  chk_unmapped_read_zero: assert property (
    reg_rd && !hit_enable && !hit_control |=> reg_rdata == '0)
    else $error("unmapped read returned data");
  chk_spent_no_start: assert property (
    conv_state == aim_pkg::CONV_SPENT |=> !conv_start)
    else $error("start after single conversion was spent");
  chk_cont_waits_start: assert property (
    conv_state == aim_pkg::CONV_ARMED_RUN && !start_event |=> !conv_start)
    else $error("continuous mode started without a start");
  chk_rsvd_mode_idle: assert property (
    &adc_control[aim_pkg::MODE_LSB +: 2] |=> !conv_start)
    else $error("reserved mode started a conversion");
  chk_oe_tracks_mode: assert property (
    !$past(sys_rst) |-> field_line9_oe == $past(eff_trig == aim_pkg::TRIG_OUT))
    else $error("trigger output enable does not follow mode");

  cov_single_run: cover property (
    conv_state == aim_pkg::CONV_ARMED_ONE ##1 conv_start);
  cov_cont_repeat: cover property (
    conv_state == aim_pkg::CONV_RUNNING && conv_start ##[1:20] conv_start);
  cov_trig_out: cover property (field_line9_out);
  cov_sw_reset: cover property (global_rst && irq_enable != '0);
  cov_trig_in_start: cover property (ext_event && conv_state == aim_pkg::CONV_ARMED_ONE);

endmodule
`default_nettype wire

// *** dv/test_adc_control_irq_mask_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module test_adc_control_irq_mask_regs;
  localparam logic [31:0] IE = aim_pkg::IRQ_ENABLE_OFFSET;
  localparam logic [31:0] CT = aim_pkg::ADC_CONTROL_OFFSET;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, en_m = 32'h0, ctl_m = 32'h0;
  logic [3:0] reg_be = 4'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ctr_irq_event = 1'b0, sw_start = 1'b0;
  logic timer_tick = 1'b0, field_line3_in = 1'b0, conv_start, field_line9_out, field_line9_oe;
  logic seen;
  logic [24:0] exp_pend;
  logic [15:0] dio_irq_event = 16'h0;
  logic [24:0] irq_pending_set;
  int bad_count = 0;
  int compares = 0;

  aim_regs uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dio_irq_event(dio_irq_event), .ctr_irq_event(ctr_irq_event),
    .irq_pending_set(irq_pending_set), .sw_start(sw_start), .timer_tick(timer_tick),
    .conv_start(conv_start), .field_line3_in(field_line3_in),
    .field_line9_out(field_line9_out), .field_line9_oe(field_line9_oe));

  always #10 ref_clk = ~ref_clk;

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) o[8*i+:8] = d[8*i+:8];
    end
    return o;
  endfunction

  // The model follows each write so later reads have an independent expectation.
  task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    if (a == IE) en_m = merge(en_m, d, be) & aim_pkg::IRQ_ENABLE_MASK;
    if (a == CT) ctl_m = merge(ctl_m, d, be) & aim_pkg::ADC_CONTROL_MASK;
    if (a == CT && be[1] && d[14]) en_m = 32'h0;
    if (a == CT && be[1] && d[15]) ctl_m = 32'h0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    `CHK("reg_rdata", exp, reg_rdata)
  endtask

  task automatic kick(input logic s, input logic t);
    sw_start = s;
    timer_tick = t;
    step();
    sw_start = 1'b0;
    timer_tick = 1'b0;
  endtask

  task automatic report_and_stop;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h49d632f5));
    repeat (4) step();
    sys_rst = 1'b0;
    step();
    rd_chk(IE, 32'h0);
    step();
    rd_chk(CT, 32'h0);
    for (int k = 0; k < 16; k++) begin
      wr(IE, 4'($urandom), $urandom);
      rd_chk(IE, en_m);
      dio_irq_event = 16'($urandom);
      ctr_irq_event = 1'($urandom);
      step();
      exp_pend = {ctr_irq_event & en_m[24], 8'h0, dio_irq_event & en_m[15:0]};
      `CHK("irq_pending_set", exp_pend, irq_pending_set)
    end
    wr(32'h0000_700c, 4'hf, 32'hffff_ffff);
    rd_chk(32'h0000_700c, 32'h0);
    wr(IE, 4'hf, 32'hffff_ffff);
    rd_chk(IE, 32'h0100_ffff);
    wr(IE, 4'h1, 32'h0000_00a5);
    rd_chk(IE, en_m);
    wr(CT, 4'h2, 32'h0000_4000);
    rd_chk(IE, 32'h0);
    wr(IE, 4'hf, 32'hffff_ffff);
    sys_rst = 1'b1;
    step();
    sys_rst = 1'b0;
    en_m = 32'h0;
    ctl_m = 32'h0;
    step();
    rd_chk(IE, en_m);
    wr(CT, 4'h1, 32'h11);
    step();
    `CHK("field_line9_oe", 1'b0, field_line9_oe)
    kick(1'b1, 1'b0);
    `CHK("conv_start", 1'b1, conv_start)
    step();
    kick(1'b1, 1'b1);
    `CHK("conv_start", 1'b0, conv_start)
    wr(CT, 4'h1, 32'h10);
    step();
    wr(CT, 4'h1, 32'h11);
    step();
    field_line3_in = 1'b1;
    step();
    seen = conv_start;
    step();
    seen = seen | conv_start;
    field_line3_in = 1'b0;
    `CHK("conv_start", 1'b1, seen)
    wr(CT, 4'h1, 32'h02);
    step();
    step();
    field_line3_in = 1'b1;
    kick(1'b0, 1'b1);
    field_line3_in = 1'b0;
    `CHK("conv_start", 1'b0, conv_start)
    step();
    kick(1'b1, 1'b0);
    `CHK("conv_start", 1'b1, conv_start)
    for (int k = 0; k < 3; k++) begin
      step();
      kick(1'b0, 1'b1);
      `CHK("conv_start", 1'b1, conv_start)
    end
    wr(CT, 4'h1, 32'h20);
    step();
    `CHK("field_line9_oe", 1'b1, field_line9_oe)
    kick(1'b0, 1'b1);
    `CHK("field_line9_out", 1'b1, field_line9_out)
    step();
    `CHK("field_line9_out", 1'b0, field_line9_out)
    wr(CT, 4'h1, 32'h33);
    step();
    rd_chk(CT, ctl_m);
    kick(1'b1, 1'b1);
    `CHK("conv_start", 1'b0, conv_start)
    `CHK("field_line9_oe", 1'b0, field_line9_oe)
    wr(CT, 4'h2, 32'h0000_8000);
    rd_chk(CT, ctl_m);
    wr(CT, 4'h1, 32'h00);
    step();
    kick(1'b1, 1'b1);
    `CHK("conv_start", 1'b0, conv_start)
    `CHK("field_line9_out", 1'b0, field_line9_out)
    report_and_stop();
  end
endmodule
`default_nettype wire
